// ### adc_frame_asserts.sv
// concurrent checks on the frame and ready pins of the serial block
`timescale 1ns/10ps
module adc_frame_asserts (
   input wire logic                      clk,                 // clock
   input wire logic                      srst,                // reset
   input wire adc_frame_pkg::spi_pins_t  spi_in,              // link pins
   input wire adc_frame_pkg::pin_out_t   pins_out,            // out pins
   input wire adc_frame_pkg::ready_cfg_t ready_cfg,           // ready setup
   input wire logic                      global_chop,         // chop mode
   input wire logic                      current_detect_mode, // detect mode
   input wire logic                      sync_pulse,          // resync
   input wire logic [5:0]                result_valid,        // new results
   input wire logic                      rx_strobe,           // word taken
   input wire logic                      cmd_strobe,          // frame done
   input wire logic [5:0]                channel_ready_flags  // flags
);
   logic lvl;
   assign lvl = ready_cfg.drive_style ? pins_out.ready_oe_n
                                      : pins_out.ready_out;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence cs_idle;
      spi_in.cs_n [*4];
   endsequence
   sequence low_run;
      !lvl [*4];
   endsequence
   ready_push_a: assert property (!ready_cfg.drive_style |->
      !pins_out.ready_oe_n) else $error("ready pin not driven");
   ready_open_a: assert property (ready_cfg.drive_style |->
      !pins_out.ready_out) else $error("released ready pin driven high");
   any_ready_a: assert property (cs_idle ##0 (lvl &&
      !ready_cfg.format && ready_cfg.source_select == 2'h1 && !global_chop
      && !current_detect_mode && !sync_pulse && result_valid != 6'h00)
      |=> !lvl) else $error("ready missed a new result");
   pulse_len_a: assert property (ready_cfg.format && $fell(lvl)
      |-> low_run ##1 lvl) else $error("ready pulse not four cycles");
   level_hold_a: assert property (cs_idle ##0 (!ready_cfg.format &&
      !lvl && result_valid == 6'h00 && !sync_pulse &&
      !current_detect_mode) |=> !lvl)
      else $error("ready level left without a read");
   dout_float_a: assert property (cs_idle |-> pins_out.dout_oe_n)
      else $error("data out driven while deselected");
   idle_quiet_a: assert property (cs_idle |->
      !rx_strobe && !cmd_strobe) else $error("word taken while idle");
   flag_set_a: assert property (result_valid[0] && !sync_pulse
      |=> channel_ready_flags[0]) else $error("ready flag not set");
endmodule

// ### adc_frame_pkg.sv
// shared constants and carrier types for the serial frame and ready block
package adc_frame_pkg;
   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int NUM_CH        = 6;
   localparam int CH_BITS       = 24;
   localparam int CMD_BITS      = 16;
   localparam int SHIFT_BITS    = 32;
   localparam int PHASE_BITS    = 10;
   localparam int FIFO_DEPTH    = 8;
   localparam int BASE_WORDS    = 8;
   // ****************************************************************
   // encodings
   // ****************************************************************
   localparam logic [1:0] WS_16       = 2'h0;
   localparam logic [1:0] WS_24       = 2'h1;
   localparam logic [1:0] WS_32_ZERO  = 2'h2;
   localparam logic [1:0] WS_32_SIGN  = 2'h3;
   localparam logic [1:0] WS_RESET    = WS_24;
   localparam logic [1:0] RS_LAGGING  = 2'h0;
   localparam logic [1:0] RS_ANY      = 2'h1;
   localparam logic [15:0] NULL_CMD   = 16'h0000;
   localparam logic [2:0] OSR_128     = 3'h0;
   localparam logic [2:0] OSR_256     = 3'h1;
   localparam logic [2:0] OSR_512     = 3'h2;
   localparam logic [2:0] OSR_1024    = 3'h3;
   localparam logic [9:0] BOUND_128   = 10'h3ed;
   localparam logic [9:0] BOUND_256   = 10'h3ad;
   localparam logic [9:0] BOUND_512   = 10'h32d;
   localparam logic [9:0] BOUND_1024  = 10'h22d;
   localparam int STATUS_READY_LSB    = 0;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_NS      = 40;
   localparam int PULSE_CYCLES  =
      (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_MCLK  = 2 ** 15;
   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } spi_pins_t;
   typedef struct packed {
      logic       dout;
      logic       dout_oe_n;
      logic       ready_out;
      logic       ready_oe_n;
   } pin_out_t;
   typedef struct packed {
      logic [1:0] source_select;
      logic       drive_style;
      logic       format;
   } ready_cfg_t;
endpackage

// ### adc_serial_frame.sv
// serial peripheral framing and data-ready signalling for six channels
`timescale 1ns/10ps
// Overview of operation
// - ready goes low on new results, or on detection in current-detect mode.
// - select 00 follows the most lagging channel's new result.
// - select 01 asserts ready for every channel's new result.
// - select 10 or 11 follows the most leading channel's new result.
// - global-chop mode ignores the ready source select.
// - phase at or below boundary moves first ready to following period.
// - boundaries -19, -83, -211, -467 per ratio; none above 1024.
// - drive style 0 drives high when idle; 1 releases like open drain.
// - level format stays low until data read, brief high before refall.
// - pulse format gives short low pulse; unread data skips one result.
// - ready event is suppressed while a frame is in progress.
// - word length 16, 24 or 32 bits; 24 after reset.
// - with timeout on, frame over 2^15 master clocks resets the link.
// - host opens with a command; device opens with previous response.
// - normal frame is eight words: response, six results, crc.
// - multi-register reads and writes lengthen the frame.
// - sixteen-bit words sit at the top, low bits zero.
// - sixteen-bit mode drops the low eight bits of each result.
// - 32-bit mode pads results with zeros or sign-extends them.
// - global chop makes all results valid when ready asserts.
// - one ready flag per channel, returned as the null response.
// - results are two's complement.
// - chip select high resets the link and floats the data output.
// - mode 1: change on rising serial clock, sample on falling.
// - two results buffered per channel; flag held until both read.
// - null command is all zero; invalid commands answer as null.
module adc_serial_frame #(
   parameter int TIMEOUT_LIMIT = adc_frame_pkg::TIMEOUT_MCLK
) (
   input  wire logic                      clk,                 // 100 MHz
   input  wire logic                      srst,                // sync reset
   input  wire adc_frame_pkg::spi_pins_t  spi_in,              // link pins
   input  wire logic                      master_clock_in,     // conv clock
   output adc_frame_pkg::pin_out_t        pins_out,            // out pins
   input  wire logic [1:0]                word_size_select,    // word size
   input  wire adc_frame_pkg::ready_cfg_t ready_cfg,           // ready setup
   input  wire logic                      timeout_en,          // frame limit
   input  wire logic                      global_chop,         // chop mode
   input  wire logic                      current_detect_mode, // detect mode
   input  wire logic                      cd_detect,           // detect event
   input  wire logic [2:0]                oversampling_ratio,  // ratio code
   input  wire logic [5:0]                channel_enable,      // enables
   input  wire logic [5:0][9:0]           channel_phase_offset, // phases
   input  wire logic                      sync_pulse,          // resync
   input  wire logic [5:0]                result_valid,        // new results
   input  wire logic [5:0][23:0]          result_data,         // results
   input  wire logic [15:0]               resp_word,           // reply word
   input  wire logic                      resp_valid,          // reply known
   input  wire logic [15:0]               crc_word,            // frame crc
   input  wire logic [7:0]                extra_words,         // added words
   input  wire logic [15:0]               reg_word,            // reg data in
   input  wire logic                      reg_valid,           // reg data ok
   output logic                           reg_ready,           // fifo room
   output logic [15:0]                    cmd_word,            // last command
   output logic                           cmd_strobe,          // frame done
   output logic [15:0]                    rx_word,             // host word
   output logic [7:0]                     rx_index,            // word number
   output logic                           rx_strobe,           // word taken
   output logic [5:0]                     channel_ready_flags  // per channel
);
   localparam int TW = $clog2(TIMEOUT_LIMIT + 1);
   localparam logic [3:0] PULSE_LEN = 4'(adc_frame_pkg::PULSE_CYCLES);
   generate
      if (TIMEOUT_LIMIT < 2 || adc_frame_pkg::PULSE_CYCLES > 15) begin : g_c
         $error("adc_serial_frame: unsupported timing parameter");
      end
   endgenerate
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [2:0]            sclk_s;
      logic [1:0]            cs_s;
      logic [1:0]            din_s;
      logic [2:0]            mclk_s;
      logic                  active;
      logic [4:0]            bitpos;
      logic [7:0]            word;
      logic [7:0]            extra;
      logic [31:0]           tx_sh;
      logic [31:0]           rx_sh;
      logic                  dout;
      logic [TW-1:0]         tmo;
      logic [5:0][1:0]       cnt;
      logic [5:0][1:0][23:0] slots;
      logic [15:0]           cmd;
      logic                  cmd_stb;
      logic [15:0]           rxw;
      logic [7:0]            rxi;
      logic                  rx_stb;
      logic                  ready_n;
      logic [3:0]            pulse;
      logic                  blip;
      logic                  unread;
      logic                  skipped;
      logic                  skip_first;
      logic [5:0]            en_q;
   } st_t;
   st_t q, d;
   logic [15:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_take;
   word_fifo #(
      .WIDTH (16),
      .DEPTH (adc_frame_pkg::FIFO_DEPTH)
   ) u_reg_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_data   (reg_word),
      .in_valid  (reg_valid),
      .in_ready  (reg_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [4:0] last_bit(input logic [1:0] ws);
      case (ws)
         adc_frame_pkg::WS_16: last_bit = 5'd15;
         adc_frame_pkg::WS_24: last_bit = 5'd23;
         default:              last_bit = 5'd31;
      endcase
   endfunction
   function automatic logic [31:0] fmt_result(input logic [1:0] ws,
                                              input logic [23:0] v);
      case (ws)
         adc_frame_pkg::WS_16:      fmt_result = {v[23:8], 16'h0000};
         adc_frame_pkg::WS_32_SIGN: fmt_result = {{8{v[23]}}, v};
         default:                   fmt_result = {v, 8'h00};
      endcase
   endfunction
   // ****************************************************************
   // controlling channel and first-ready boundary
   // ****************************************************************
   logic [2:0] lag_ch, lead_ch, ctrl_ch;
   logic       has_bound;
   logic [9:0] bound;
   always_comb begin
      lag_ch  = 3'd0;
      lead_ch = 3'd0;
      for (int i = 1; i < adc_frame_pkg::NUM_CH; i++) begin
         if (channel_enable[i] && ($signed(channel_phase_offset[i]) >
             $signed(channel_phase_offset[lag_ch]) || !channel_enable[lag_ch]))
            lag_ch = 3'(i);
         if (channel_enable[i] && ($signed(channel_phase_offset[i]) <
             $signed(channel_phase_offset[lead_ch]) ||
             !channel_enable[lead_ch]))
            lead_ch = 3'(i);
      end
      if (global_chop || ready_cfg.source_select == adc_frame_pkg::RS_ANY)
         ctrl_ch = 3'd5;
      else if (ready_cfg.source_select == adc_frame_pkg::RS_LAGGING)
         ctrl_ch = lag_ch;
      else
         ctrl_ch = lead_ch;
      has_bound = 1'b1;
      case (oversampling_ratio)
         adc_frame_pkg::OSR_128:  bound = adc_frame_pkg::BOUND_128;
         adc_frame_pkg::OSR_256:  bound = adc_frame_pkg::BOUND_256;
         adc_frame_pkg::OSR_512:  bound = adc_frame_pkg::BOUND_512;
         adc_frame_pkg::OSR_1024: bound = adc_frame_pkg::BOUND_1024;
         default: begin
            bound     = 10'h000;
            has_bound = 1'b0;
         end
      endcase
   end
   // ****************************************************************
   // next state
   // ****************************************************************
   logic        s_rise, s_fall, m_rise, link_rst, word_done, frame_done;
   logic        trig, ctrl_done, first_evt;
   logic [5:0]  pop;
   logic [7:0]  ch_base, ch_idx;
   logic [31:0] load;
   logic [31:0] rx_next;
   logic [15:0] status_word;
   always_comb begin
      d            = q;
      d.sclk_s     = {q.sclk_s[1:0], spi_in.sclk};
      d.cs_s       = {q.cs_s[0], spi_in.cs_n};
      d.din_s      = {q.din_s[0], spi_in.din};
      d.mclk_s     = {q.mclk_s[1:0], master_clock_in};
      d.cmd_stb    = 1'b0;
      d.rx_stb     = 1'b0;
      s_rise       = q.sclk_s[1] && !q.sclk_s[2];
      s_fall       = !q.sclk_s[1] && q.sclk_s[2];
      m_rise       = q.mclk_s[1] && !q.mclk_s[2];
      ch_base      = 8'd1 + q.extra;
      ch_idx       = q.word - ch_base;
      pop          = 6'h00;
      fifo_take    = 1'b0;
      word_done    = 1'b0;
      frame_done   = 1'b0;
      ctrl_done    = 1'b0;
      load         = 32'h0000_0000;
      rx_next      = {q.rx_sh[30:0], q.din_s[1]};
      status_word  = 16'h0000;
      for (int i = 0; i < adc_frame_pkg::NUM_CH; i++)
         status_word[adc_frame_pkg::STATUS_READY_LSB + i] =
            (q.cnt[i] != 2'd0);
      // timeout counts master clock edges from the first serial clock
      link_rst = q.cs_s[1];
      if (q.active && m_rise) begin
         d.tmo = q.tmo + 1'b1;
         if (timeout_en && q.tmo == TW'(TIMEOUT_LIMIT - 1))
            link_rst = 1'b1;
      end
      // word source and shifter, mode 1
      if (!link_rst && s_rise) begin
         if (q.bitpos == 5'd0) begin
            if (q.word == 8'd0) begin
               d.active = 1'b1;
               d.tmo    = '0;
               d.extra  = extra_words;
               if (resp_valid && q.cmd != adc_frame_pkg::NULL_CMD)
                  load = {resp_word, 16'h0000};
               else
                  load = {status_word, 16'h0000};
            end else if (q.word < ch_base) begin
               fifo_take = fifo_valid;
               load = {fifo_valid ? fifo_data : 16'h0000, 16'h0000};
            end else if (ch_idx < 8'(adc_frame_pkg::NUM_CH)) begin
               load = fmt_result(word_size_select,
                                 q.slots[ch_idx[2:0]][0]);
               pop[ch_idx[2:0]] = 1'b1;
            end else begin
               load = {crc_word, 16'h0000};
            end
            d.tx_sh = {load[30:0], 1'b0};
            d.dout  = load[31];
         end else begin
            d.tx_sh = {q.tx_sh[30:0], 1'b0};
            d.dout  = q.tx_sh[31];
         end
      end
      if (!link_rst && s_fall && q.active) begin
         d.rx_sh  = rx_next;
         d.bitpos = q.bitpos + 1'b1;
         if (q.bitpos == last_bit(word_size_select)) begin
            word_done = 1'b1;
            d.bitpos  = 5'd0;
            d.word    = q.word + 1'b1;
         end
      end
      if (word_done) begin
         case (word_size_select)
            adc_frame_pkg::WS_16: d.rxw = rx_next[15:0];
            adc_frame_pkg::WS_24: d.rxw = rx_next[23:8];
            default:              d.rxw = rx_next[31:16];
         endcase
         d.rxi    = q.word;
         d.rx_stb = 1'b1;
         if (q.word == 8'd0)
            d.cmd = d.rxw;
         if (q.word == ch_base + 8'(ctrl_ch))
            ctrl_done = 1'b1;
         if (q.word == ch_base + 8'(adc_frame_pkg::NUM_CH)) begin
            frame_done = 1'b1;
            d.cmd_stb  = 1'b1;
            d.active   = 1'b0;
            d.word     = 8'd0;
         end
      end
      if (link_rst) begin
         d.active = 1'b0;
         d.bitpos = 5'd0;
         d.word   = 8'd0;
         d.tmo    = '0;
         d.dout   = 1'b0;
      end
      // two-deep result store per channel; a pop and a push in the same cycle both take effect
      for (int i = 0; i < adc_frame_pkg::NUM_CH; i++) begin
         if (pop[i] && q.cnt[i] != 2'd0) begin
            d.slots[i][0] = q.slots[i][1];
            d.cnt[i]      = q.cnt[i] - 2'd1;
         end
         if (result_valid[i]) begin
            if (d.cnt[i] == 2'd2) begin
               d.slots[i][0] = d.slots[i][1];
               d.slots[i][1] = result_data[i];
            end else begin
               d.slots[i][d.cnt[i][0]] = result_data[i];
               d.cnt[i] = d.cnt[i] + 2'd1;
            end
         end
      end
      // ready event selection
      d.en_q    = channel_enable;
      first_evt = sync_pulse || (channel_enable[ctrl_ch] && !q.en_q[ctrl_ch]);
      if (current_detect_mode)
         trig = cd_detect;
      else if (global_chop || ready_cfg.source_select ==
               adc_frame_pkg::RS_ANY)
         trig = |result_valid;
      else
         trig = result_valid[ctrl_ch];
      if (q.active)
         trig = 1'b0;
      if (first_evt)
         d.skip_first = has_bound && !global_chop &&
                        $signed(channel_phase_offset[ctrl_ch]) <=
                        $signed(bound);
      else if (trig && q.skip_first) begin
         d.skip_first = 1'b0;
         trig         = 1'b0;
      end
      // ready output shaping
      if (ctrl_done || (frame_done && global_chop))
         d.unread = 1'b0;
      if (!ready_cfg.format) begin
         if (ctrl_done || frame_done)
            d.ready_n = 1'b1;
         if (q.blip) begin
            d.blip    = 1'b0;
            d.ready_n = 1'b0;
         end
         if (trig) begin
            d.blip    = !q.ready_n;
            d.ready_n = !q.ready_n;
         end
         d.pulse = 4'd0;
      end else begin
         d.blip = 1'b0;
         if (q.pulse != 4'd0)
            d.pulse = q.pulse - 4'd1;
         if (trig) begin
            if (d.unread && !q.skipped) begin
               d.skipped = 1'b1;
            end else begin
               d.skipped = 1'b0;
               d.unread  = 1'b1;
               d.pulse   = PULSE_LEN;
            end
         end
         d.ready_n = (d.pulse == 4'd0);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         q         <= '0;
         q.ready_n <= 1'b1;
         q.cs_s    <= 2'h3;
      end else begin
         q <= d;
      end
   end
   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      pins_out.dout       = q.dout;
      pins_out.dout_oe_n  = q.cs_s[1];
      pins_out.ready_out  = ready_cfg.drive_style ? 1'b0 : q.ready_n;
      pins_out.ready_oe_n = ready_cfg.drive_style & q.ready_n;
   end
   assign cmd_word   = q.cmd;
   assign cmd_strobe = q.cmd_stb;
   assign rx_word    = q.rxw;
   assign rx_index   = q.rxi;
   assign rx_strobe  = q.rx_stb;
   always_comb begin
      for (int i = 0; i < adc_frame_pkg::NUM_CH; i++)
         channel_ready_flags[i] = (q.cnt[i] != 2'd0);
   end
endmodule

// ### spi_host.sv
// serial host model: mode 1 controller clocking whole frames
`timescale 1ns/10ps
module spi_host (
   input  wire logic dout, // device data
   output logic      sclk, // serial clock
   output logic      cs_n, // select, low
   output logic      din   // host data
);
   logic [31:0] rx_q [16];
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      din  = 1'h0;
   end
   task automatic frame(input logic [15:0] cmd, input int words,
                        input int bits);
      logic [31:0] sh;
      cs_n = 1'h0;
      #80;
      for (int w = 0; w < words; w++) begin
         sh = (w == 0) ? {cmd, 16'h0000} : 32'h0000_0000;
         rx_q[w] = 32'h0000_0000;
         for (int b = 0; b < bits; b++) begin
            sclk = 1'h1;
            din = sh[31];
            sh = sh << 1;
            #40 sclk = 1'h0;
            rx_q[w] = {rx_q[w][30:0], dout};
            #40;
         end
      end
      cs_n = 1'h1;
      din = ~din;
   endtask
endmodule

// ### tb_top.sv
// testbench: word sizes, register words and ready pin formats
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   logic             clk, srst, master_clock_in, timeout_en, global_chop;
   logic             current_detect_mode, cd_detect, sync_pulse, resp_valid;
   logic             reg_valid, reg_ready, cmd_strobe, rx_strobe;
   logic             sclk, cs_n, din;
   logic [1:0]       word_size_select;
   logic [2:0]       oversampling_ratio;
   logic [5:0]       channel_enable, result_valid, channel_ready_flags;
   logic [5:0][9:0]  channel_phase_offset;
   logic [5:0][23:0] result_data;
   logic [15:0]      resp_word, crc_word, reg_word, cmd_word, rx_word;
   logic [7:0]       extra_words, rx_index;
   int               num_checks, fails, cyc;
   adc_frame_pkg::spi_pins_t  spi_in;
   adc_frame_pkg::pin_out_t   pins_out;
   adc_frame_pkg::ready_cfg_t ready_cfg;
   assign spi_in = '{sclk, cs_n, din};
   spi_host i_spi_host (.dout(pins_out.dout ^ pins_out.dout_oe_n),
      .sclk, .cs_n, .din);
   adc_serial_frame #(.TIMEOUT_LIMIT(16)) i_adc_serial_frame (.clk, .srst,
      .spi_in, .master_clock_in, .pins_out, .word_size_select, .ready_cfg,
      .timeout_en, .global_chop, .current_detect_mode, .cd_detect,
      .oversampling_ratio, .channel_enable, .channel_phase_offset,
      .sync_pulse, .result_valid, .result_data, .resp_word, .resp_valid,
      .crc_word, .extra_words, .reg_word, .reg_valid, .reg_ready, .cmd_word,
      .cmd_strobe, .rx_word, .rx_index, .rx_strobe, .channel_ready_flags);
   function automatic int nb(input int s);
      return (s == 0) ? 16 : (s == 1) ? 24 : 32;
   endfunction
   function automatic logic [31:0] top16(input logic [15:0] x, input int s);
      return {x, 16'h0000} >> (32 - nb(s));
   endfunction
   function automatic logic [31:0] res(input logic [23:0] d, input int s);
      case (s)
         0: return {16'h0000, d[23:8]};
         1: return {8'h00, d};
         2: return {d, 8'h00};
         default: return {{8{d[23]}}, d};
      endcase
   endfunction
   task automatic push();
      @(negedge clk);
      result_valid = 6'h3f;
      @(negedge clk);
      result_valid = 6'h00;
      @(negedge clk);
   endtask
   task automatic t_words();
      for (int s = 0; s < 4; s++) begin
         word_size_select = 2'(s);
         push();
         `CHK(pins_out.ready_out, 1'h0)
         `CHK(channel_ready_flags, 6'h3f)
         i_spi_host.frame(16'h0000, 8, nb(s));
         repeat (8) @(negedge clk);
         `CHK(i_spi_host.rx_q[0], top16(16'h003f, s))
         for (int c = 0; c < 6; c++)
            `CHK(i_spi_host.rx_q[c + 1], res(result_data[c], s))
         `CHK(i_spi_host.rx_q[7], top16(crc_word, s))
         `CHK(pins_out.ready_out, 1'h1)
         `CHK(channel_ready_flags, 6'h00)
      end
   endtask
   task automatic t_fifo();
      word_size_select = adc_frame_pkg::WS_RESET;
      for (int k = 0; k < 8; k++) begin
         @(negedge clk);
         reg_word = 16'ha000 + 16'(k);
         reg_valid = 1'h1;
      end
      @(negedge clk);
      reg_valid = 1'h0;
      `CHK(reg_ready, 1'h0)
      extra_words = 8'h08;
      push();
      i_spi_host.frame(16'h1234, 16, 24);
      repeat (8) @(negedge clk);
      for (int k = 0; k < 8; k++)
         `CHK(i_spi_host.rx_q[k+1], {8'h00, 16'ha000+16'(k), 8'h00})
      `CHK(i_spi_host.rx_q[15], {8'h00, crc_word, 8'h00})
      `CHK(cmd_word, 16'h1234)
      `CHK(reg_ready, 1'h1)
      `CHK(rx_index, 8'h0f)
      extra_words = 8'h00;
   endtask
   task automatic t_pulse();
      @(negedge clk);
      ready_cfg = '{2'h1, 1'h1, 1'h1};
      push();
      `CHK(pins_out.ready_oe_n, 1'h0)
      `CHK(pins_out.ready_out, 1'h0)
      repeat (6) @(negedge clk);
      `CHK(pins_out.ready_oe_n, 1'h1)
      push();
      `CHK(pins_out.ready_oe_n, 1'h1)
      repeat (6) @(negedge clk);
      push();
      `CHK(pins_out.ready_oe_n, 1'h0)
   endtask
   task automatic t_tmo();
      timeout_en = 1'h1;
      i_spi_host.frame(16'h5555, 1, 24);
      `CHK(cmd_word, 16'h1234)
   endtask
   task automatic complete_run();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always #32 master_clock_in = ~master_clock_in;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      {srst, master_clock_in, timeout_en, global_chop} = 4'h8;
      {current_detect_mode, cd_detect, sync_pulse, resp_valid} = 4'h0;
      {reg_valid, result_valid, extra_words, reg_word} = 31'h0000_0000;
      {oversampling_ratio, channel_phase_offset} = 63'h0000_0000_0000_0000;
      {channel_enable, resp_word, crc_word} = {6'h3f, 16'h0000, 16'hc3a5};
      {cyc, num_checks, fails} = 96'h0000_0000_0000_0000_0000_0000;
      word_size_select = adc_frame_pkg::WS_RESET;
      ready_cfg = '{adc_frame_pkg::RS_ANY, 1'h0, 1'h0};
      for (int c = 0; c < 6; c++)
         result_data[c] = 24'h7f_0001 + 24'(c) * 24'h21_1111;
      repeat (5) @(posedge clk);
      @(negedge clk);
      srst = 1'h0;
      repeat (4) @(negedge clk);
      t_words();
      t_fifo();
      t_pulse();
      t_tmo();
      complete_run();
   end
endmodule
bind adc_serial_frame adc_frame_asserts i_adc_frame_asserts (.clk, .srst,
   .spi_in, .pins_out, .ready_cfg, .global_chop, .current_detect_mode,
   .sync_pulse, .result_valid, .rx_strobe, .cmd_strobe,
   .channel_ready_flags);

// ### word_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,       // system clock
   input  wire logic             srst,      // sync reset, high
   input  wire logic [WIDTH-1:0] in_data,   // write data
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // room available
   output logic [WIDTH-1:0]      out_data,  // head word
   output logic                  out_valid, // head word present
   input  wire logic             out_ready  // head word taken
);
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("word_fifo depth must be a power of two, at least 2");
      end
   endgenerate
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_st_t;
   fifo_st_t q, d;
   logic wr, rd;
   assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rp];
   assign wr        = in_valid && in_ready;
   assign rd        = out_valid && out_ready;
   always_comb begin
      d = q;
      if (wr) begin
         d.mem[q.wp] = in_data;
         d.wp        = q.wp + 1'b1;
      end
      if (rd) begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
